// >>> fsmc_failsafe_monitor_regs.sv
// Failsafe monitor control and status register bank with its pin-side effects.
// Assumes the serial bus engine presents byte accesses as wr/rd strobes, one cycle each.
`include "fsmc_map.svh"
module fsmc_failsafe_monitor_regs (
	input wire logic core_clk,
	input wire logic rst,
	input wire fsmc_pkg::fsmc_bus_t reg_bus,
	output logic [7:0] reg_rdata,
	input wire logic pwm_one_base_tick,
	input wire logic pwm_two_base_tick,
	output logic pwm_one_period_tick,
	output logic pwm_two_period_tick,
	output logic [7:0] correction_enable,
	input wire logic monitor_cycle_done,
	input wire logic [7:0] threshold_calc,
	input wire logic [7:0] vset_raw,
	input wire logic thermistor_mode,
	input wire fsmc_pkg::fsmc_trip_t trips,
	input wire logic regulator_power_ok_n,
	input wire logic thermal_shutdown_flag,
	input wire logic aux_power_ok_n,
	input wire logic main_supply_power_good,
	input wire logic trip_notify_enable,
	input wire logic interrupt_pending,
	input wire logic ara_answered,
	input wire fsmc_pkg::fsmc_err_t bus_errors,
	output logic system_shutdown_out_n,
	output logic trip_notification_out,
	output logic alert_interrupt_out_n,
	output logic monitoring_enable,
	output logic fan_drive_enable,
	output logic watchdog_clear,
	output logic watchdog_run
);
	fsmc_pkg::fsmc_regs_t regs_reg;
	fsmc_pkg::fsmc_regs_t regs_next;
	logic both_good;
	logic trip_any;
	logic [7:0] fs_status;
	logic [7:0] fs_cfg;
	logic cfg_wr;
	logic [7:0] err_set;

	assign both_good = !aux_power_ok_n && main_supply_power_good;

	// Status bits four and five are left out on purpose
	assign trip_any = !trips.external_trip_input_one
		|| !trips.external_trip_input_two
		|| !trips.external_trip_input_three
		|| !trips.internal_hardware_failsafe_n;

	assign cfg_wr = reg_bus.wr && reg_bus.addr == `FSMC_OFS_FSCF;

	fsmc_failsafe_keep u_keep (
		.core_clk(core_clk),
		.rst(rst),
		.both_good(both_good),
		.clear_failsafe_latch(regs_reg.clear_latch),
		.trips(trips),
		.regulator_power_ok_n(regulator_power_ok_n),
		.thermal_shutdown_flag(thermal_shutdown_flag),
		.cfg_wr(cfg_wr),
		.cfg_wdata(reg_bus.wdata),
		.status(fs_status),
		.cfg_bits(fs_cfg)
	);

	fsmc_pwm_divider u_div_one (
		.core_clk(core_clk),
		.rst(rst),
		.base_tick(pwm_one_base_tick),
		.divide(regs_reg.div1),
		.period_tick(pwm_one_period_tick)
	);

	fsmc_pwm_divider u_div_two (
		.core_clk(core_clk),
		.rst(rst),
		.base_tick(pwm_two_base_tick),
		.divide(regs_reg.div2),
		.period_tick(pwm_two_period_tick)
	);

	always_comb begin
		err_set = 8'h00;
		err_set[`FSMC_ERR_CRC] = bus_errors.crc;
		err_set[`FSMC_ERR_ARA] = bus_errors.ara;
		err_set[`FSMC_ERR_STOP] = bus_errors.stop;
		err_set[`FSMC_ERR_NO_NACK] = bus_errors.missing_host_nack_flag;
	end

	always_comb begin
		regs_next = regs_reg;

		// Software writes; read-only offsets fall through untouched
		if (reg_bus.wr) begin
			if (reg_bus.addr == `FSMC_OFS_CORR) begin
				regs_next.corr = reg_bus.wdata;
			end else if (reg_bus.addr == `FSMC_OFS_DIV1) begin
				regs_next.div1 = reg_bus.wdata;
			end else if (reg_bus.addr == `FSMC_OFS_DIV2) begin
				regs_next.div2 = reg_bus.wdata;
			end else if (reg_bus.addr == `FSMC_OFS_SFR) begin
				regs_next.clear_latch = reg_bus.wdata[`FSMC_SFR_CLEAR];
				regs_next.int_enable = reg_bus.wdata[`FSMC_SFR_INT_ENABLE];
			end
		end

		// A query answer in the same cycle as a write still disarms
		if (ara_answered) begin
			regs_next.int_enable = 1'b0;
		end

		// Refresh of the threshold is the only path into it
		if (monitor_cycle_done) begin
			if (thermistor_mode) begin
				regs_next.trip = vset_raw;
			end else begin
				regs_next.trip = threshold_calc;
			end
		end

		// Error log clears on read, but a new cause in that cycle survives
		if (reg_bus.rd && reg_bus.addr == `FSMC_OFS_ERR) begin
			regs_next.err = err_set;
		end else begin
			regs_next.err = regs_reg.err | err_set;
		end

		regs_next.rdata = regs_reg.rdata;
		if (reg_bus.rd) begin
			if (reg_bus.addr == `FSMC_OFS_CORR) begin
				regs_next.rdata = regs_reg.corr;
			end else if (reg_bus.addr == `FSMC_OFS_DIV1) begin
				regs_next.rdata = regs_reg.div1;
			end else if (reg_bus.addr == `FSMC_OFS_DIV2) begin
				regs_next.rdata = regs_reg.div2;
			end else if (reg_bus.addr == `FSMC_OFS_TRIP) begin
				regs_next.rdata = regs_reg.trip;
			end else if (reg_bus.addr == `FSMC_OFS_FSST) begin
				regs_next.rdata = fs_status;
			end else if (reg_bus.addr == `FSMC_OFS_FSCF) begin
				regs_next.rdata = fs_cfg;
			end else if (reg_bus.addr == `FSMC_OFS_ERR) begin
				regs_next.rdata = regs_reg.err;
			end else if (reg_bus.addr == `FSMC_OFS_SFR) begin
				regs_next.rdata = 8'h00;
				regs_next.rdata[`FSMC_SFR_CLEAR] = regs_reg.clear_latch;
				regs_next.rdata[`FSMC_SFR_INT_ENABLE] = regs_reg.int_enable;
			end else begin
				regs_next.rdata = 8'h00;
			end
		end

		// Pin-side effects, registered so the pins never glitch
		regs_next.shdn_n = !(trip_any && both_good);
		regs_next.notify = trip_any && both_good && trip_notify_enable;
		regs_next.alert_n = !(interrupt_pending && regs_reg.int_enable);
		regs_next.fan_en = both_good;
		regs_next.mon_en = both_good || fs_cfg[`FSMC_CFG_KEEP_MON];
		regs_next.wd_clr = !fs_cfg[`FSMC_CFG_WD] && !both_good;
		regs_next.wd_run = !fs_cfg[`FSMC_CFG_WD] && both_good;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regs_reg.corr <= `FSMC_RST_CORR;
			regs_reg.div1 <= `FSMC_RST_DIV;
			regs_reg.div2 <= `FSMC_RST_DIV;
			regs_reg.trip <= `FSMC_RST_TRIP;
			regs_reg.err <= `FSMC_RST_ERR;
			regs_reg.clear_latch <= `FSMC_RST_CLEAR;
			regs_reg.int_enable <= `FSMC_RST_INT_ENABLE;
			regs_reg.rdata <= 8'h00;
			regs_reg.shdn_n <= 1'b1;
			regs_reg.notify <= 1'b0;
			regs_reg.alert_n <= 1'b1;
			regs_reg.mon_en <= 1'b0;
			regs_reg.fan_en <= 1'b0;
			regs_reg.wd_clr <= 1'b0;
			regs_reg.wd_run <= 1'b0;
		end else begin
			regs_reg <= regs_next;
		end
	end

	assign reg_rdata = regs_reg.rdata;
	assign correction_enable = regs_reg.corr;
	assign system_shutdown_out_n = regs_reg.shdn_n;
	assign trip_notification_out = regs_reg.notify;
	assign alert_interrupt_out_n = regs_reg.alert_n;
	assign monitoring_enable = regs_reg.mon_en;
	assign fan_drive_enable = regs_reg.fan_en;
	assign watchdog_clear = regs_reg.wd_clr;
	assign watchdog_run = regs_reg.wd_run;

	a_corr_write: assert property (@(posedge core_clk) disable iff (rst)
		reg_bus.wr && reg_bus.addr == `FSMC_OFS_CORR
		|=> correction_enable == $past(reg_bus.wdata))
		else $error("correction enable not written");

	a_trip_refresh: assert property (@(posedge core_clk) disable iff (rst)
		monitor_cycle_done && !thermistor_mode
		|=> regs_reg.trip == $past(threshold_calc))
		else $error("threshold not refreshed");

	a_trip_raw: assert property (@(posedge core_clk) disable iff (rst)
		monitor_cycle_done && thermistor_mode
		|=> regs_reg.trip == $past(vset_raw))
		else $error("raw voltage not loaded");

	a_trip_readonly: assert property (@(posedge core_clk) disable iff (rst)
		!monitor_cycle_done |=> regs_reg.trip == $past(regs_reg.trip))
		else $error("threshold changed without refresh");

	a_shdn_cause: assert property (@(posedge core_clk) disable iff (rst)
		!system_shutdown_out_n |-> $past(trip_any) && $past(both_good))
		else $error("shutdown without trip source");

	a_unpowered_block: assert property (@(posedge core_clk) disable iff (rst)
		!both_good |=> system_shutdown_out_n && !trip_notification_out)
		else $error("shutdown not blocked");

	a_fan_off: assert property (@(posedge core_clk) disable iff (rst)
		!both_good |=> !fan_drive_enable && monitoring_enable == $past(fs_cfg[`FSMC_CFG_KEEP_MON]))
		else $error("power loss mode wrong");

	a_wd_reset: assert property (@(posedge core_clk) disable iff (rst)
		!fs_cfg[`FSMC_CFG_WD] && !both_good |=> watchdog_clear && !watchdog_run)
		else $error("watchdog not reset");

	a_int_gate: assert property (@(posedge core_clk) disable iff (rst)
		!regs_reg.int_enable |=> alert_interrupt_out_n)
		else $error("interrupt with enable low");

	a_ara_clear: assert property (@(posedge core_clk) disable iff (rst)
		ara_answered |=> !regs_reg.int_enable ##1 alert_interrupt_out_n)
		else $error("enable not cleared by query");

	a_err_log: assert property (@(posedge core_clk) disable iff (rst)
		bus_errors.crc |=> regs_reg.err[`FSMC_ERR_CRC])
		else $error("crc error not logged");

	a_sfr_zero: assert property (@(posedge core_clk) disable iff (rst)
		reg_bus.rd && reg_bus.addr == `FSMC_OFS_SFR
		|=> reg_rdata[7:4] == 4'h0 && reg_rdata[1:0] == 2'h0)
		else $error("reserved bits not zero");
endmodule

// >>> fsmc_map.svh
// Offsets, field positions and reset values of the failsafe monitor registers.
// Assumes an 8-bit register address space behind the serial bus engine.
`ifndef FSMC_MAP_SVH
`define FSMC_MAP_SVH
`define FSMC_OFS_CORR 8'h70
`define FSMC_OFS_DIV1 8'h72
`define FSMC_OFS_DIV2 8'h73
`define FSMC_OFS_TRIP 8'h75
`define FSMC_OFS_FSST 8'h76
`define FSMC_OFS_FSCF 8'h77
`define FSMC_OFS_ERR 8'h7a
`define FSMC_OFS_SFR 8'h7c
`define FSMC_RST_CORR 8'hff
`define FSMC_RST_DIV 8'h28
`define FSMC_RST_TRIP 8'h7f
`define FSMC_RST_FSST 8'h00
`define FSMC_RST_FSCF 8'h00
`define FSMC_RST_ERR 8'h00
`define FSMC_FS_HW_CAUSE 0
`define FSMC_FS_TRIP_ONE 1
`define FSMC_FS_TRIP_TWO 2
`define FSMC_FS_TRIP_THREE 3
`define FSMC_FS_THERMAL 4
`define FSMC_FS_REGULATOR 5
`define FSMC_CFG_KEEP_MON 0
`define FSMC_CFG_WD 1
`define FSMC_SFR_INT_ENABLE 2
`define FSMC_SFR_CLEAR 3
`define FSMC_ERR_NO_NACK 0
`define FSMC_ERR_STOP 5
`define FSMC_ERR_ARA 6
`define FSMC_ERR_CRC 7
`define FSMC_MASK_FSCF 8'h03
`define FSMC_RST_INT_ENABLE 1'b1
`define FSMC_RST_CLEAR 1'b0
`endif

// >>> fsmc_pkg.sv
// Types shared by the failsafe monitor register bank.
// Assumes fsmc_map.svh for all numeric values.
package fsmc_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fsmc_bus_t;
	typedef struct packed {
		logic external_trip_input_three;
		logic external_trip_input_two;
		logic external_trip_input_one;
		logic internal_hardware_failsafe_n;
	} fsmc_trip_t;
	typedef struct packed {
		logic crc;
		logic ara;
		logic stop;
		logic missing_host_nack_flag;
	} fsmc_err_t;
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] cfg_bits;
	} fsmc_keep_t;
	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} fsmc_div_t;
	typedef struct packed {
		logic [7:0] corr;
		logic [7:0] div1;
		logic [7:0] div2;
		logic [7:0] trip;
		logic [7:0] err;
		logic clear_latch;
		logic int_enable;
		logic [7:0] rdata;
		logic shdn_n;
		logic notify;
		logic alert_n;
		logic mon_en;
		logic fan_en;
		logic wd_clr;
		logic wd_run;
	} fsmc_regs_t;
endpackage

// >>> fsmc_pwm_divider.sv
// Divides a PWM base clock enable by an 8-bit setting.
// Assumes base_tick is a one-cycle pulse in the core_clk domain.
`include "fsmc_map.svh"
module fsmc_pwm_divider (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic base_tick,
	input wire logic [7:0] divide,
	output logic period_tick
);
	fsmc_pkg::fsmc_div_t div_reg;
	fsmc_pkg::fsmc_div_t div_next;

	always_comb begin
		div_next = div_reg;
		div_next.tick = 1'b0;
		if (base_tick) begin
			// Zero setting parks the output rather than dividing by 256
			if (divide == 8'h00) begin
				div_next.cnt = 8'h00;
			end else if (div_reg.cnt >= 8'(divide - 8'h01)) begin
				div_next.cnt = 8'h00;
				div_next.tick = 1'b1;
			end else begin
				div_next.cnt = 8'(div_reg.cnt + 8'h01);
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	assign period_tick = div_reg.tick;

	a_tick_cause: assert property (@(posedge core_clk) disable iff (rst)
		period_tick |-> $past(base_tick) && $past(divide) != 8'h00)
		else $error("period tick without base tick");
endmodule

// >>> fsmc_failsafe_keep.sv
// Retained failsafe cause latch and failsafe configuration.
// Assumes rst is the always-on supply reset; main supply loss is seen only as power-good.
`include "fsmc_map.svh"
module fsmc_failsafe_keep (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic both_good,
	input wire logic clear_failsafe_latch,
	input wire fsmc_pkg::fsmc_trip_t trips,
	input wire logic regulator_power_ok_n,
	input wire logic thermal_shutdown_flag,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] status,
	output logic [7:0] cfg_bits
);
	fsmc_pkg::fsmc_keep_t keep_reg;
	fsmc_pkg::fsmc_keep_t keep_next;
	logic [7:0] cause;

	always_comb begin
		cause = 8'h00;
		cause[`FSMC_FS_HW_CAUSE] = !trips.internal_hardware_failsafe_n;
		cause[`FSMC_FS_TRIP_ONE] = !trips.external_trip_input_one;
		cause[`FSMC_FS_TRIP_TWO] = !trips.external_trip_input_two;
		cause[`FSMC_FS_TRIP_THREE] = !trips.external_trip_input_three;
		cause[`FSMC_FS_THERMAL] = thermal_shutdown_flag;
		cause[`FSMC_FS_REGULATOR] = !regulator_power_ok_n;
		keep_next = keep_reg;
		if (cfg_wr) begin
			keep_next.cfg_bits = cfg_wdata & `FSMC_MASK_FSCF;
		end
		// Frozen while unpowered; a pending clear acts once power returns
		if (both_good) begin
			if (clear_failsafe_latch) begin
				keep_next.status = `FSMC_RST_FSST;
			end else begin
				keep_next.status = keep_reg.status | cause;
			end
		end
	end

	// Only rst of the always-on supply touches this state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			keep_reg <= {`FSMC_RST_FSST, `FSMC_RST_FSCF};
		end else begin
			keep_reg <= keep_next;
		end
	end

	assign status = keep_reg.status;
	assign cfg_bits = keep_reg.cfg_bits;

	a_status_frozen: assert property (@(posedge core_clk) disable iff (rst)
		!both_good |=> status == $past(status))
		else $error("status changed while unpowered");
	a_clear_holds: assert property (@(posedge core_clk) disable iff (rst)
		both_good && clear_failsafe_latch |=> status == 8'h00)
		else $error("clear did not hold status at default");
	a_trip_sticky: assert property (@(posedge core_clk) disable iff (rst)
		both_good && !clear_failsafe_latch && !trips.external_trip_input_one
		|=> status[`FSMC_FS_TRIP_ONE] ##1 (status[`FSMC_FS_TRIP_ONE] || $past(clear_failsafe_latch && both_good)))
		else $error("trip cause not latched");
endmodule

// >>> fsmc_host_model.sv
// Host side model: single-byte register writes and reads on the bank's strobe bus.
// Assumes the bank takes wr/rd on a rising edge and answers one cycle later.
module fsmc_host_model (
	input wire logic core_clk,
	output fsmc_pkg::fsmc_bus_t reg_bus,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_bus = '0;
	end
	// Released lines show the inverse, so a stale address never looks valid
	task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		reg_bus.wr <= 1'h1;
		reg_bus.addr <= addr;
		reg_bus.wdata <= data;
		@(posedge core_clk);
		reg_bus.wr <= 1'h0;
		reg_bus.addr <= ~addr;
		reg_bus.wdata <= ~data;
	endtask
	task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
		@(posedge core_clk);
		reg_bus.rd <= 1'h1;
		reg_bus.addr <= addr;
		@(posedge core_clk);
		reg_bus.rd <= 1'h0;
		reg_bus.addr <= ~addr;
		#1;
		data = reg_rdata;
	endtask
endmodule

// >>> tb.sv
// Self-checking bench for the failsafe monitor register bank.
// Assumes fsmc_pkg and fsmc_host_model are compiled before it.
`include "fsmc_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	fsmc_pkg::fsmc_bus_t reg_bus;
	logic [7:0] reg_rdata;
	logic pwm_one_base_tick = 1'h0;
	logic pwm_two_base_tick = 1'h0;
	logic pwm_one_period_tick;
	logic pwm_two_period_tick;
	logic [7:0] correction_enable;
	logic monitor_cycle_done = 1'h0;
	logic [7:0] threshold_calc = 8'h00;
	logic [7:0] vset_raw = 8'h00;
	logic thermistor_mode = 1'h0;
	fsmc_pkg::fsmc_trip_t trips = 4'hf;
	logic regulator_power_ok_n = 1'h1;
	logic thermal_shutdown_flag = 1'h0;
	logic aux_power_ok_n = 1'h0;
	logic main_supply_power_good = 1'h1;
	logic trip_notify_enable = 1'h1;
	logic interrupt_pending = 1'h0;
	logic ara_answered = 1'h0;
	fsmc_pkg::fsmc_err_t bus_errors = '0;
	logic system_shutdown_out_n;
	logic trip_notification_out;
	logic alert_interrupt_out_n;
	logic monitoring_enable;
	logic fan_drive_enable;
	logic watchdog_clear;
	logic watchdog_run;
	int miscompares = 0;
	int comparisons = 0;
	logic [7:0] p1_cnt = 8'h00;
	logic [7:0] p2_cnt = 8'h00;
	logic [7:0] n1;
	logic [7:0] n2;
	logic [7:0] ofs [9] = '{8'h70, 8'h72, 8'h73, 8'h75, 8'h76, 8'h77, 8'h7a, 8'h7c, 8'h71};
	logic [7:0] rv [9] = '{8'hff, 8'h28, 8'h28, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};

	always #5 core_clk = ~core_clk;

	fsmc_failsafe_monitor_regs dut (
		.core_clk(core_clk), .rst(rst), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
		.pwm_one_base_tick(pwm_one_base_tick), .pwm_two_base_tick(pwm_two_base_tick),
		.pwm_one_period_tick(pwm_one_period_tick), .pwm_two_period_tick(pwm_two_period_tick),
		.correction_enable(correction_enable), .monitor_cycle_done(monitor_cycle_done),
		.threshold_calc(threshold_calc), .vset_raw(vset_raw), .thermistor_mode(thermistor_mode),
		.trips(trips), .regulator_power_ok_n(regulator_power_ok_n),
		.thermal_shutdown_flag(thermal_shutdown_flag), .aux_power_ok_n(aux_power_ok_n),
		.main_supply_power_good(main_supply_power_good), .trip_notify_enable(trip_notify_enable),
		.interrupt_pending(interrupt_pending), .ara_answered(ara_answered), .bus_errors(bus_errors),
		.system_shutdown_out_n(system_shutdown_out_n), .trip_notification_out(trip_notification_out),
		.alert_interrupt_out_n(alert_interrupt_out_n), .monitoring_enable(monitoring_enable),
		.fan_drive_enable(fan_drive_enable), .watchdog_clear(watchdog_clear), .watchdog_run(watchdog_run)
	);
	fsmc_host_model host (
		.core_clk(core_clk),
		.reg_bus(reg_bus),
		.reg_rdata(reg_rdata)
	);

	// Period ticks are single cycles, so counting edges counts pulses
	always @(posedge core_clk) begin
		if (pwm_one_period_tick === 1'h1) p1_cnt <= p1_cnt + 8'h01;
		if (pwm_two_period_tick === 1'h1) p2_cnt <= p2_cnt + 8'h01;
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t pin got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		host.read_byte(addr, d);
		chk8(d, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#50000;
		miscompares++;
		tally_and_finish();
	end

	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		cyc(1);
		for (int i = 0; i < 9; i++) begin
			rd_chk(ofs[i], rv[i]);
		end
		chk8(correction_enable, 8'hff);
		chk1(watchdog_run, 1'h1);
		chk1(watchdog_clear, 1'h0);
		host.write_byte(`FSMC_OFS_CORR, 8'h5a);
		cyc(1);
		chk8(correction_enable, 8'h5a);
		rd_chk(`FSMC_OFS_CORR, 8'h5a);
		// Refused writes to read-only and unmapped places
		host.write_byte(`FSMC_OFS_TRIP, 8'h00);
		host.write_byte(`FSMC_OFS_FSST, 8'hff);
		host.write_byte(`FSMC_OFS_ERR, 8'hff);
		host.write_byte(8'h71, 8'hff);
		rd_chk(`FSMC_OFS_TRIP, 8'h7f);
		rd_chk(`FSMC_OFS_FSST, 8'h00);
		rd_chk(`FSMC_OFS_ERR, 8'h00);
		rd_chk(8'h71, 8'h00);
		host.write_byte(`FSMC_OFS_FSCF, 8'hfc);
		rd_chk(`FSMC_OFS_FSCF, 8'h00);
		host.write_byte(`FSMC_OFS_SFR, 8'hff);
		rd_chk(`FSMC_OFS_SFR, 8'h0c);
		host.write_byte(`FSMC_OFS_SFR, 8'h04);
		// Odd and even divides catch an off-by-one in the count
		host.write_byte(`FSMC_OFS_DIV1, 8'h03);
		host.write_byte(`FSMC_OFS_DIV2, 8'h02);
		n1 = p1_cnt;
		n2 = p2_cnt;
		for (int i = 0; i < 12; i++) begin
			@(posedge core_clk);
			pwm_one_base_tick <= (i < 9);
			pwm_two_base_tick <= 1'h1;
			@(posedge core_clk);
			pwm_one_base_tick <= 1'h0;
			pwm_two_base_tick <= 1'h0;
		end
		cyc(3);
		chk8(p1_cnt - n1, 8'h03);
		chk8(p2_cnt - n2, 8'h06);
		for (int m = 0; m < 2; m++) begin
			@(posedge core_clk);
			threshold_calc <= 8'h55;
			vset_raw <= 8'h99;
			thermistor_mode <= m[0];
			monitor_cycle_done <= 1'h1;
			@(posedge core_clk);
			monitor_cycle_done <= 1'h0;
			rd_chk(`FSMC_OFS_TRIP, (m == 1) ? 8'h99 : 8'h55);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			trips <= fsmc_pkg::fsmc_trip_t'(4'hf ^ (4'h1 << i));
			// Last pass drops the notify enable; shutdown must still assert
			trip_notify_enable <= (i != 3);
			cyc(2);
			chk1(system_shutdown_out_n, 1'h0);
			chk1(trip_notification_out, (i != 3));
			@(posedge core_clk);
			trips <= 4'hf;
			trip_notify_enable <= 1'h1;
		end
		cyc(2);
		rd_chk(`FSMC_OFS_FSST, 8'h0f);
		@(posedge core_clk);
		regulator_power_ok_n <= 1'h0;
		thermal_shutdown_flag <= 1'h1;
		cyc(2);
		chk1(system_shutdown_out_n, 1'h1);
		chk1(trip_notification_out, 1'h0);
		@(posedge core_clk);
		regulator_power_ok_n <= 1'h1;
		thermal_shutdown_flag <= 1'h0;
		rd_chk(`FSMC_OFS_FSST, 8'h3f);
		host.write_byte(`FSMC_OFS_SFR, 8'h0c);
		@(posedge core_clk);
		trips <= 4'h7;
		cyc(2);
		rd_chk(`FSMC_OFS_FSST, 8'h00);
		host.write_byte(`FSMC_OFS_SFR, 8'h04);
		cyc(2);
		rd_chk(`FSMC_OFS_FSST, 8'h08);
		// Main supply lost while a trip is active
		@(posedge core_clk);
		trips <= 4'hb;
		main_supply_power_good <= 1'h0;
		cyc(2);
		chk1(system_shutdown_out_n, 1'h1);
		chk1(trip_notification_out, 1'h0);
		chk1(monitoring_enable, 1'h0);
		chk1(fan_drive_enable, 1'h0);
		chk1(watchdog_clear, 1'h1);
		chk1(watchdog_run, 1'h0);
		rd_chk(`FSMC_OFS_FSST, 8'h08);
		host.write_byte(`FSMC_OFS_FSCF, 8'h01);
		cyc(1);
		chk1(monitoring_enable, 1'h1);
		chk1(fan_drive_enable, 1'h0);
		host.write_byte(`FSMC_OFS_SFR, 8'h0c);
		cyc(2);
		rd_chk(`FSMC_OFS_FSST, 8'h08);
		@(posedge core_clk);
		trips <= 4'hf;
		main_supply_power_good <= 1'h1;
		cyc(2);
		rd_chk(`FSMC_OFS_FSST, 8'h00);
		chk1(watchdog_run, 1'h1);
		host.write_byte(`FSMC_OFS_SFR, 8'h04);
		host.write_byte(`FSMC_OFS_FSCF, 8'h02);
		cyc(1);
		chk1(watchdog_run, 1'h0);
		@(posedge core_clk);
		aux_power_ok_n <= 1'h1;
		cyc(2);
		chk1(fan_drive_enable, 1'h0);
		chk1(watchdog_clear, 1'h0);
		@(posedge core_clk);
		aux_power_ok_n <= 1'h0;
		interrupt_pending <= 1'h1;
		cyc(2);
		chk1(alert_interrupt_out_n, 1'h0);
		host.write_byte(`FSMC_OFS_SFR, 8'h00);
		cyc(1);
		chk1(alert_interrupt_out_n, 1'h1);
		host.write_byte(`FSMC_OFS_SFR, 8'h04);
		@(posedge core_clk);
		ara_answered <= 1'h1;
		@(posedge core_clk);
		ara_answered <= 1'h0;
		cyc(1);
		chk1(alert_interrupt_out_n, 1'h1);
		rd_chk(`FSMC_OFS_SFR, 8'h00);
		host.write_byte(`FSMC_OFS_SFR, 8'h04);
		cyc(1);
		chk1(alert_interrupt_out_n, 1'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			bus_errors <= fsmc_pkg::fsmc_err_t'(4'h1 << i);
			@(posedge core_clk);
			bus_errors <= '0;
		end
		rd_chk(`FSMC_OFS_ERR, 8'he1);
		rd_chk(`FSMC_OFS_ERR, 8'h00);
		tally_and_finish();
	end
endmodule
